/* rtl/tmb_consts.svh */
/*
  Constants of the eight channel timer bank: addresses, field positions,
  reset values and counts. Assumes it is included by bare name.
*/
`ifndef TMB_CONSTS_SVH
`define TMB_CONSTS_SVH
`define TMB_ADDR_MODE 16'hdf42
`define TMB_ADDR_RUN 16'hdf43
`define TMB_ADDR_FLAGS 16'hdf44
`define TMB_ADDR_IEN 16'hdf46
`define TMB_ADDR_CNT_BASE 16'hdf60
`define TMB_RST_BYTE 8'h00
`define TMB_T4_EXT_BIT 0
`define TMB_T4_PIN_BIT 1
`define TMB_UART_SRC_LSB 4
`define TMB_WDOG_BIT 0
`define TMB_WDOG_TIMER 0
`define TMB_RATE_T3 3
`define TMB_RATE_T4 4
`define TMB_SLOW_TIMER 2
`define TMB_FDIV_MSB 3
`define TMB_WDOG_PULSE_CYC 2'h2
`define TMB_WDOG_LAST_CYC 2'h1
`endif

/* rtl/tmb_pkg.sv */
/*
  Types of the eight channel timer bank.
  Assumes the constants header is compiled alongside.
*/
package tmb_pkg;
  typedef enum logic [1:0] {
    TMB_WD_OFF = 2'b00,
    TMB_WD_ARMED = 2'b01,
    TMB_WD_PULSE = 2'b10
  } tmb_wd_state_t;
endpackage

/* rtl/tmb_timer.sv */
/*
  One sixteen bit down counter with high and low reload latches.
  Assumes count-clock edges arrive as one-cycle pulses on SYS_CLK.
*/
`timescale 1ns/1ps
`include "tmb_consts.svh"
module tmb_timer
  import tmb_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic tick_fall,
  input wire logic tick_rise,
  input wire logic lo_wr,
  input wire logic hi_wr,
  input wire logic load,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] cnt_lo,
  output logic [W-1:0] cnt_hi,
  output logic expire
);
  logic [W-1:0] lo_latch_reg;
  logic [W-1:0] hi_latch_reg;
  logic [W-1:0] lo_reg;
  logic [W-1:0] hi_reg;

  assign cnt_lo = lo_reg;
  assign cnt_hi = hi_reg;
  assign expire = run & tick_rise & (hi_reg == '0) & ~hi_wr & ~load;

  always_ff @(posedge clk) begin
    if (srst) begin
      lo_latch_reg <= '0;
      hi_latch_reg <= '0;
    end else begin
      if (lo_wr) begin
        lo_latch_reg <= wdata;
      end
      if (hi_wr) begin
        hi_latch_reg <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lo_reg <= '0;
      hi_reg <= '0;
    end else if (hi_wr) begin
      hi_reg <= wdata;
      lo_reg <= lo_latch_reg;
    end else if (load || expire) begin
      hi_reg <= hi_latch_reg;
      lo_reg <= lo_latch_reg;
    end else if (run && tick_fall) begin
      lo_reg <= lo_reg - 1'b1;
      if (lo_reg == '0) begin
        hi_reg <= hi_reg - 1'b1;
      end
    end
  end

  chk_low_write_latch: assert property (@(posedge clk) disable iff (srst)
    lo_wr && !hi_wr && !load && !tick_fall && !expire |=> $stable(lo_reg))
    else $error("low write changed the running count");
  chk_high_write_load: assert property (@(posedge clk) disable iff (srst)
    hi_wr |=> hi_reg == $past(wdata) && lo_reg == $past(lo_latch_reg))
    else $error("high write did not load both counters");
  chk_fall_decrement: assert property (@(posedge clk) disable iff (srst)
    run && tick_fall && !hi_wr && !load && !expire |=> lo_reg == W'($past(lo_reg) - 1'b1))
    else $error("low counter missed a decrement");
  chk_expire_reload: assert property (@(posedge clk) disable iff (srst)
    expire |=> hi_reg == $past(hi_latch_reg) && lo_reg == $past(lo_latch_reg))
    else $error("expiry did not reload");
  chk_halt_holds: assert property (@(posedge clk) disable iff (srst)
    !run && !hi_wr && !load |=> $stable({hi_reg, lo_reg}))
    else $error("halted timer changed");
endmodule

/* rtl/tmb_top.sv */
/*
  Eight channel timer bank with watchdog, rate source select and
  pin output. Assumes the processor core drives the internal byte bus
  on SYS_CLK and that FAST_CLOCK and PORT6_BIT_ZERO are pin levels.
*/
`timescale 1ns/1ps
`include "tmb_consts.svh"
module tmb_top
  import tmb_pkg::*;
#(
  parameter int NT = 8,
  parameter int NU = 4
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [7:0] BUS_RDATA,
  input wire logic FAST_CLOCK,
  input wire logic PORT6_BIT_ZERO,
  output logic PORT6_BIT_ONE_OUT,
  output logic PORT6_BIT_ONE_OE_N,
  output logic CHIP_RESET_LINE_N,
  output logic TMR_IRQ,
  output logic [2:0] TMR_IRQ_VEC,
  output logic [NU-1:0] UART_RATE_TICK
);
  // ----------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------
  logic [7:0] timer_mode_select_reg;
  logic [7:0] timer_run_gate_reg;
  logic [7:0] timer_irq_enable_reg;
  logic [7:0] timer_irq_flags_reg;
  logic [7:0] timer_irq_flags_next;
  logic [7:0] flag_clr;
  logic fast_clock_s1_reg;
  logic fast_clock_s2_reg;
  logic fast_clock_d_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic [3:0] fdiv_reg;
  logic sys_phase_reg;
  logic [NT-1:0] cclk_lvl;
  logic [NT-1:0] cclk_prev_reg;
  logic [NT-1:0] tick_fall;
  logic [NT-1:0] tick_rise;
  logic [NT-1:0] lo_wr;
  logic [NT-1:0] hi_wr;
  logic [NT-1:0] load;
  logic [NT-1:0] expire;
  logic [7:0] cnt_lo [NT];
  logic [7:0] cnt_hi [NT];
  logic watchdog_run_bit;
  logic wr_mode;
  logic wr_run;
  logic wr_flags;
  logic wr_ien;
  tmb_wd_state_t wd_state_reg;
  logic [1:0] wd_cnt_reg;
  logic rst_line_n_reg;
  logic irq_reg;
  logic [2:0] irq_vec_reg;
  logic [2:0] irq_vec_next;
  logic [7:0] rdata_reg;
  logic t4_out_reg;
  logic t4_oe_n_reg;
  logic [NU-1:0] uart_tick_reg;

  assign watchdog_run_bit = timer_run_gate_reg[`TMB_WDOG_BIT];
  assign BUS_RDATA = rdata_reg;
  assign PORT6_BIT_ONE_OUT = t4_out_reg;
  assign PORT6_BIT_ONE_OE_N = t4_oe_n_reg;
  assign CHIP_RESET_LINE_N = rst_line_n_reg;
  assign TMR_IRQ = irq_reg;
  assign TMR_IRQ_VEC = irq_vec_reg;
  assign UART_RATE_TICK = uart_tick_reg;

  // ----------------------------------------------------------
  // Pin synchronisers and count clocks
  // ----------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      fast_clock_s1_reg <= 1'b0;
      fast_clock_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end else begin
      fast_clock_s1_reg <= FAST_CLOCK;
      fast_clock_s2_reg <= fast_clock_s1_reg;
      ext_s1_reg <= PORT6_BIT_ZERO;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // Divide by sixteen runs on fast-clock rising edges
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      fast_clock_d_reg <= 1'b0;
      fdiv_reg <= 4'h0;
    end else begin
      fast_clock_d_reg <= fast_clock_s2_reg;
      if (fast_clock_s2_reg && !fast_clock_d_reg) begin
        fdiv_reg <= fdiv_reg + 4'h1;
      end
    end
  end

  // System clock timers see one edge of each kind every two cycles
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sys_phase_reg <= 1'b0;
    end else begin
      sys_phase_reg <= ~sys_phase_reg;
    end
  end

  always_comb begin
    cclk_lvl = {NT{fast_clock_s2_reg}};
    cclk_lvl[0] = sys_phase_reg;
    cclk_lvl[1] = sys_phase_reg;
    cclk_lvl[`TMB_SLOW_TIMER] = fdiv_reg[`TMB_FDIV_MSB];
    if (timer_mode_select_reg[`TMB_T4_EXT_BIT]) begin
      cclk_lvl[`TMB_RATE_T4] = ext_s2_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cclk_prev_reg <= '0;
    end else begin
      cclk_prev_reg <= cclk_lvl;
    end
  end

  assign tick_fall = cclk_prev_reg & ~cclk_lvl;
  assign tick_rise = ~cclk_prev_reg & cclk_lvl;

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  assign wr_mode = BUS_WR && (BUS_ADDR == `TMB_ADDR_MODE);
  assign wr_run = BUS_WR && (BUS_ADDR == `TMB_ADDR_RUN);
  assign wr_flags = BUS_WR && (BUS_ADDR == `TMB_ADDR_FLAGS);
  assign wr_ien = BUS_WR && (BUS_ADDR == `TMB_ADDR_IEN);

  always_comb begin
    lo_wr = '0;
    hi_wr = '0;
    for (int n = 0; n < NT; n++) begin
      if (BUS_WR && BUS_ADDR == 16'(`TMB_ADDR_CNT_BASE + 2 * n)) begin
        lo_wr[n] = 1'b1;
      end else if (BUS_WR && BUS_ADDR == 16'(`TMB_ADDR_CNT_BASE + 2 * n + 1)) begin
        hi_wr[n] = 1'b1;
      end
    end
  end

  // Only a 0 to 1 step of the watchdog run bit reloads; 1 to 0 is inert
  always_comb begin
    load = '0;
    load[`TMB_WDOG_TIMER] = wr_run && BUS_WDATA[`TMB_WDOG_BIT] && !watchdog_run_bit;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      timer_mode_select_reg <= `TMB_RST_BYTE;
      timer_run_gate_reg <= `TMB_RST_BYTE;
      timer_irq_enable_reg <= `TMB_RST_BYTE;
    end else if (wr_mode) begin
      timer_mode_select_reg <= BUS_WDATA;
    end else if (wr_run) begin
      timer_run_gate_reg <= BUS_WDATA;
    end else if (wr_ien) begin
      timer_irq_enable_reg <= BUS_WDATA;
    end
  end

  // Counter reads return the live count so software can poll
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_reg <= `TMB_RST_BYTE;
    end else if (BUS_RD) begin
      rdata_reg <= `TMB_RST_BYTE;
      if (BUS_ADDR == `TMB_ADDR_MODE) begin
        rdata_reg <= timer_mode_select_reg;
      end else if (BUS_ADDR == `TMB_ADDR_RUN) begin
        rdata_reg <= timer_run_gate_reg;
      end else if (BUS_ADDR == `TMB_ADDR_FLAGS) begin
        rdata_reg <= timer_irq_flags_reg;
      end else if (BUS_ADDR == `TMB_ADDR_IEN) begin
        rdata_reg <= timer_irq_enable_reg;
      end else begin
        for (int n = 0; n < NT; n++) begin
          if (BUS_ADDR == 16'(`TMB_ADDR_CNT_BASE + 2 * n)) begin
            rdata_reg <= cnt_lo[n];
          end else if (BUS_ADDR == 16'(`TMB_ADDR_CNT_BASE + 2 * n + 1)) begin
            rdata_reg <= cnt_hi[n];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Timers
  // ----------------------------------------------------------
  for (genvar g = 0; g < NT; g++) begin : g_tmr
    tmb_timer #(
      .W(8)
    ) u_tmr (
      .clk(SYS_CLK),
      .srst(SRST),
      .run(timer_run_gate_reg[g]),
      .tick_fall(tick_fall[g]),
      .tick_rise(tick_rise[g]),
      .lo_wr(lo_wr[g]),
      .hi_wr(hi_wr[g]),
      .load(load[g]),
      .wdata(BUS_WDATA),
      .cnt_lo(cnt_lo[g]),
      .cnt_hi(cnt_hi[g]),
      .expire(expire[g])
    );
  end

  // ----------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------
  // A clear never hides an expiry in the same cycle
  assign flag_clr = wr_flags ? BUS_WDATA : 8'h00;
  assign timer_irq_flags_next = (timer_irq_flags_reg & ~flag_clr) | expire;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      timer_irq_flags_reg <= `TMB_RST_BYTE;
    end else begin
      timer_irq_flags_reg <= timer_irq_flags_next;
    end
  end

  // Highest bit wins the vector
  always_comb begin
    irq_vec_next = 3'h0;
    for (int n = 0; n < NT; n++) begin
      if (timer_irq_flags_reg[n] && timer_irq_enable_reg[n]) begin
        irq_vec_next = 3'(n);
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      irq_reg <= 1'b0;
      irq_vec_reg <= 3'h0;
    end else begin
      irq_reg <= |(timer_irq_flags_reg & timer_irq_enable_reg);
      irq_vec_reg <= irq_vec_next;
    end
  end

  // ----------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wd_state_reg <= TMB_WD_OFF;
      wd_cnt_reg <= 2'h0;
      rst_line_n_reg <= 1'b1;
    end else begin
      case (wd_state_reg)
        TMB_WD_OFF: begin
          if (load[`TMB_WDOG_TIMER]) begin
            wd_state_reg <= TMB_WD_ARMED;
          end
        end
        TMB_WD_ARMED: begin
          if (expire[`TMB_WDOG_TIMER]) begin
            wd_state_reg <= TMB_WD_PULSE;
            wd_cnt_reg <= `TMB_WDOG_PULSE_CYC;
            rst_line_n_reg <= 1'b0;
          end
        end
        TMB_WD_PULSE: begin
          if (wd_cnt_reg == `TMB_WDOG_LAST_CYC) begin
            rst_line_n_reg <= 1'b1;
            wd_state_reg <= TMB_WD_OFF;
          end else begin
            wd_cnt_reg <= wd_cnt_reg - 2'h1;
          end
        end
        default: begin
          wd_state_reg <= TMB_WD_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Timer 4 pin and UART rate ticks
  // ----------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      t4_out_reg <= 1'b0;
      t4_oe_n_reg <= 1'b1;
    end else begin
      t4_oe_n_reg <= ~timer_mode_select_reg[`TMB_T4_PIN_BIT];
      if (expire[`TMB_RATE_T4]) begin
        t4_out_reg <= ~t4_out_reg;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      uart_tick_reg <= '0;
    end else begin
      for (int u = 0; u < NU; u++) begin
        uart_tick_reg[u] <= timer_mode_select_reg[`TMB_UART_SRC_LSB + u] ?
          expire[`TMB_RATE_T4] : expire[`TMB_RATE_T3];
      end
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  chk_flag_sets: assert property (@(posedge SYS_CLK) disable iff (SRST)
    |expire |=> (timer_irq_flags_reg & $past(expire)) == $past(expire))
    else $error("expiry did not raise its flag");
  chk_flag_clear: assert property (@(posedge SYS_CLK) disable iff (SRST)
    wr_flags && BUS_WDATA[0] && !expire[0] |=> !timer_irq_flags_reg[0] ##1
      (timer_irq_flags_reg[0] == $past(expire[0])))
    else $error("flag clear misbehaved");
  chk_irq_masked: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (timer_irq_flags_reg & timer_irq_enable_reg) == 8'h00 |=> !TMR_IRQ)
    else $error("interrupt without enabled flag");
  chk_wdog_pulse: assert property (@(posedge SYS_CLK) disable iff (SRST)
    $fell(CHIP_RESET_LINE_N) |-> !CHIP_RESET_LINE_N ##1 !CHIP_RESET_LINE_N ##1 CHIP_RESET_LINE_N)
    else $error("reset pulse not two cycles");
  chk_wdog_quiet: assert property (@(posedge SYS_CLK) disable iff (SRST)
    wd_state_reg == TMB_WD_OFF |=> CHIP_RESET_LINE_N)
    else $error("watchdog fired before arming");
  chk_t4_pin_gate: assert property (@(posedge SYS_CLK) disable iff (SRST)
    ##1 PORT6_BIT_ONE_OE_N == !$past(timer_mode_select_reg[`TMB_T4_PIN_BIT]))
    else $error("pin enable does not follow mode");
  chk_run0_reload: assert property (@(posedge SYS_CLK) disable iff (SRST)
    load[0] && !hi_wr[0] |=> cnt_hi[0] == $past(g_tmr[0].u_tmr.hi_latch_reg))
    else $error("run bit rise did not reload");

  cov_wdog_fire: cover property (@(posedge SYS_CLK) disable iff (SRST) $fell(CHIP_RESET_LINE_N));
  cov_irq_raise: cover property (@(posedge SYS_CLK) disable iff (SRST) $rose(TMR_IRQ));
  cov_set_clear: cover property (@(posedge SYS_CLK) disable iff (SRST) wr_flags && |(expire & BUS_WDATA));
  cov_ext_clock: cover property (@(posedge SYS_CLK) disable iff (SRST)
    timer_mode_select_reg[`TMB_T4_EXT_BIT] && expire[`TMB_RATE_T4]);
endmodule

/* verif/tmb_cpu_model.sv */
/*
  Processor core model: byte writes and reads on the internal bus.
  Assumes the bench calls its tasks and that strobes move on the
  falling edge of SYS_CLK.
*/
`timescale 1ns/1ps
module tmb_cpu_model (
  input wire logic SYS_CLK,
  output logic [15:0] BUS_ADDR,
  output logic [7:0] BUS_WDATA,
  output logic BUS_WR,
  output logic BUS_RD,
  input wire logic [7:0] BUS_RDATA
);
  initial begin
    BUS_ADDR = 16'h0000;
    BUS_WDATA = 8'h00;
    BUS_WR = 1'b0;
    BUS_RD = 1'b0;
  end

  // Released lines flip, so a stale address or byte is never reused
  task automatic idle();
    BUS_ADDR = ~BUS_ADDR;
    BUS_WDATA = ~BUS_WDATA;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge SYS_CLK);
    BUS_ADDR = a;
    BUS_WDATA = d;
    BUS_WR = 1'b1;
    @(negedge SYS_CLK);
    BUS_WR = 1'b0;
    idle();
  endtask

  // Data is taken one full cycle after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge SYS_CLK);
    BUS_ADDR = a;
    BUS_RD = 1'b1;
    @(negedge SYS_CLK);
    BUS_RD = 1'b0;
    idle();
    @(negedge SYS_CLK);
    d = BUS_RDATA;
  endtask
endmodule

/* verif/eight_channel_timer_bank_tb_top.sv */
/*
  Self-checking bench of the timer bank: registers, counters, flags,
  watchdog and timer 4 routing. Assumes the processor model drives
  the bus and this bench drives the clock pins.
*/
`timescale 1ns/1ps
`include "tmb_consts.svh"
module eight_channel_timer_bank_tb_top;
  logic sys_clk, srst, bus_wr, bus_rd, p6_go;
  logic fast_clock = 1'b0;
  logic port6_bit_zero = 1'b0;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, rv, lo, hi;
  logic p61_out, p61_oe_n, chip_reset_line_n, tmr_irq;
  logic [2:0] tmr_irq_vec;
  logic [3:0] uart_rate_tick;
  int n_mismatch, samples_checked, i, k;
  int fc = 0;
  integer seed;

  tmb_top dut_u (.SYS_CLK(sys_clk), .SRST(srst), .BUS_ADDR(bus_addr),
    .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata),
    .FAST_CLOCK(fast_clock), .PORT6_BIT_ZERO(port6_bit_zero), .PORT6_BIT_ONE_OUT(p61_out),
    .PORT6_BIT_ONE_OE_N(p61_oe_n), .CHIP_RESET_LINE_N(chip_reset_line_n),
    .TMR_IRQ(tmr_irq), .TMR_IRQ_VEC(tmr_irq_vec), .UART_RATE_TICK(uart_rate_tick));
  tmb_cpu_model cpu_u (.SYS_CLK(sys_clk), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
    .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Pin clocks: each level lasts several system cycles to suit the syncs
  always @(negedge sys_clk) begin
    fc <= fc + 1;
    if (fc % 3 == 0) fast_clock <= ~fast_clock;
    if (p6_go && fc % 4 == 0) port6_bit_zero <= ~port6_bit_zero;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string msg);
    cpu_u.rd(a, rv);
    cmp8(rv, exp, msg);
  endtask

  // Bounded poll of one flag bit; running out counts as a mismatch
  task automatic wait_flag(input int b);
    for (k = 0; k < 60; k++) begin
      cpu_u.rd(`TMB_ADDR_FLAGS, rv);
      if (rv[b] === 1'b1) break;
    end
    cmp8({7'h00, rv[b]}, 8'h01, "flag set");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    $display("CHECK FAILED %0t run limit reached", $time);
    close_out();
  end

  initial begin
    seed = 32'h92fa;
    srst = 1'b1;
    p6_go = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    rd_chk(`TMB_ADDR_MODE, 8'h00, "mode reset");
    rd_chk(`TMB_ADDR_RUN, 8'h00, "run reset");
    rd_chk(16'hdf50, 8'h00, "unmapped");
    cmp8({7'h00, chip_reset_line_n}, 8'h01, "reset line idle");
    // Random readback; run bit 0 kept low so the watchdog stays unarmed
    for (i = 0; i < 4; i++) begin
      hi = 8'($random(seed));
      cpu_u.wr(`TMB_ADDR_MODE, hi);
      rd_chk(`TMB_ADDR_MODE, hi, "mode rw");
      cpu_u.wr(`TMB_ADDR_RUN, hi & 8'hfe);
      rd_chk(`TMB_ADDR_RUN, hi & 8'hfe, "run rw");
    end
    cpu_u.wr(`TMB_ADDR_RUN, 8'h00);
    cpu_u.wr(`TMB_ADDR_MODE, 8'h00);
    // Latch and counter access on every halted timer
    for (i = 0; i < 8; i++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      cpu_u.wr(`TMB_ADDR_CNT_BASE + 2 * i + 1, 8'h00);
      cpu_u.wr(`TMB_ADDR_CNT_BASE + 2 * i, lo);
      rd_chk(`TMB_ADDR_CNT_BASE + 2 * i, 8'h00, "low write");
      cpu_u.wr(`TMB_ADDR_CNT_BASE + 2 * i + 1, hi);
      rd_chk(`TMB_ADDR_CNT_BASE + 2 * i + 1, hi, "high load");
      repeat (20) @(negedge sys_clk);
      rd_chk(`TMB_ADDR_CNT_BASE + 2 * i, lo, "low live");
    end
    // Timer 1 counts 2:1 with high latch 1 on the system clock
    cpu_u.wr(`TMB_ADDR_CNT_BASE + 2, 8'h02);
    cpu_u.wr(`TMB_ADDR_CNT_BASE + 3, 8'h01);
    cpu_u.wr(`TMB_ADDR_FLAGS, 8'hff);
    cpu_u.wr(`TMB_ADDR_RUN, 8'h02);
    for (i = 0; i < 6; i++) begin
      cpu_u.rd(`TMB_ADDR_CNT_BASE + 2, rv);
      cmp8({7'h00, rv inside {8'h02, 8'h01, 8'h00, 8'hff}}, 8'h01, "low range");
      cpu_u.rd(`TMB_ADDR_CNT_BASE + 3, rv);
      cmp8({7'h00, rv inside {8'h01, 8'h00}}, 8'h01, "high range");
    end
    wait_flag(1);
    cpu_u.wr(`TMB_ADDR_RUN, 8'h00);
    cpu_u.wr(`TMB_ADDR_IEN, 8'h02);
    repeat (2) @(negedge sys_clk);
    cmp8({7'h00, tmr_irq}, 8'h01, "irq on");
    cmp8({5'h00, tmr_irq_vec}, 8'h01, "irq vector");
    cpu_u.wr(`TMB_ADDR_IEN, 8'h00);
    repeat (2) @(negedge sys_clk);
    cmp8({7'h00, tmr_irq}, 8'h00, "irq masked");
    cpu_u.wr(`TMB_ADDR_FLAGS, 8'h00);
    cpu_u.rd(`TMB_ADDR_FLAGS, rv);
    cmp8({7'h00, rv[1]}, 8'h01, "zero write keeps");
    cpu_u.wr(`TMB_ADDR_FLAGS, 8'h02);
    cpu_u.rd(`TMB_ADDR_FLAGS, rv);
    cmp8({7'h00, rv[1]}, 8'h00, "one write clears");
    // A high write reloads a disabled timer before any restart
    cpu_u.wr(`TMB_ADDR_CNT_BASE + 3, 8'h01);
    rd_chk(`TMB_ADDR_CNT_BASE + 2, 8'h02, "reload low");
    // Watchdog: high latch zero, low latch one, so expiry comes at the next rise
    // whichever count edge arrives first; armed by the first rise of run bit 0
    cpu_u.wr(`TMB_ADDR_CNT_BASE, 8'h01);
    cpu_u.wr(`TMB_ADDR_CNT_BASE + 1, 8'h00);
    cpu_u.wr(`TMB_ADDR_RUN, 8'h01);
    i = 0;
    k = 0;
    while (chip_reset_line_n !== 1'b0 && i < 40) begin
      @(negedge sys_clk);
      i++;
    end
    while (chip_reset_line_n === 1'b0 && k < 8) begin
      @(negedge sys_clk);
      k++;
    end
    cmp8(8'(k), 8'h02, "reset pulse width");
    i = 0;
    repeat (60) begin
      @(negedge sys_clk);
      if (chip_reset_line_n !== 1'b1) i++;
    end
    cmp8(8'(i), 8'h00, "no rearm");
    // Rise of run bit 0 reloads from latches; the fall freezes the count
    cpu_u.wr(`TMB_ADDR_RUN, 8'h00);
    cpu_u.wr(`TMB_ADDR_CNT_BASE + 1, 8'h40);
    cpu_u.wr(`TMB_ADDR_CNT_BASE, 8'h77);
    cpu_u.wr(`TMB_ADDR_RUN, 8'h01);
    cpu_u.wr(`TMB_ADDR_RUN, 8'h00);
    rd_chk(`TMB_ADDR_CNT_BASE + 1, 8'h40, "run rise high");
    cpu_u.rd(`TMB_ADDR_CNT_BASE, lo);
    cmp8({7'h00, lo inside {[8'h74 : 8'h77]}}, 8'h01, "run rise low");
    repeat (20) @(negedge sys_clk);
    rd_chk(`TMB_ADDR_CNT_BASE, lo, "run fall holds");
    // Timer 4 on the external pin, routed to the port and to rate 0
    cpu_u.wr(`TMB_ADDR_CNT_BASE + 8, 8'h00);
    cpu_u.wr(`TMB_ADDR_CNT_BASE + 9, 8'h00);
    cpu_u.wr(`TMB_ADDR_MODE, 8'h13);
    cpu_u.wr(`TMB_ADDR_FLAGS, 8'hff);
    cpu_u.wr(`TMB_ADDR_RUN, 8'h10);
    cmp8({7'h00, p61_oe_n}, 8'h00, "pin on");
    repeat (30) @(negedge sys_clk);
    cpu_u.rd(`TMB_ADDR_FLAGS, rv);
    cmp8({7'h00, rv[4]}, 8'h00, "pin still");
    // The pin output toggles once per expiry; only one expiry follows here
    hi = {7'h00, ~p61_out};
    p6_go = 1'b1;
    i = 0;
    while (uart_rate_tick[0] !== 1'b1 && i < 100) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    cmp8({4'h0, uart_rate_tick}, 8'h01, "rate from t4");
    wait_flag(4);
    cmp8({7'h00, p61_out}, hi, "pin toggles");
    cpu_u.wr(`TMB_ADDR_MODE, 8'h00);
    @(negedge sys_clk);
    cmp8({7'h00, p61_oe_n}, 8'h01, "pin off");
    close_out();
  end
endmodule
